// file: fl_st0_pkg.sv
// Constants for the floppy result status byte zero block.
// Assumes a single 125 MHz core clock and an AXI4-Lite register port.
package fl_st0_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned STEP_TIME_US = 3;
    localparam int unsigned STEP_CYC = STEP_TIME_US * CLK_MHZ;
    localparam int unsigned RECAL_STEPS = 77;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_RESULT = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_CTRL_STAT = 8'h14;

    // ==========================================================
    // Result byte fields
    localparam int unsigned B_CODE_LSB = 6;
    localparam int unsigned B_SEEK_DONE = 5;
    localparam int unsigned B_EQUIP_FAULT = 4;
    localparam int unsigned B_NOT_READY = 3;
    localparam int unsigned B_HEAD = 2;
    localparam logic [1:0] CODE_NORMAL = 2'h0;
    localparam logic [1:0] CODE_ABNORMAL = 2'h1;
    localparam logic [7:0] RESULT_RST = 8'h00;

    // ==========================================================
    // Command word fields and opcodes
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_UNIT_LSB = 2;
    localparam int unsigned CMD_HEAD_BIT = 4;
    localparam int unsigned CMD_CNT_LSB = 8;
    localparam logic [1:0] OP_SEEK = 2'h0;
    localparam logic [1:0] OP_RECAL = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h3;

    // ==========================================================
    // Interrupt and bus answers
    localparam int unsigned IRQ_DONE = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_STEP = 4'h2,
        ST_CAP = 4'h4,
        ST_HOLD = 4'h8
    } fl_state_t;
endpackage

// file: fl_step_if.sv
// Carrier between the status block and its step pulse generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface fl_step_if;
    logic start;
    logic [7:0] count;
    logic to_trk0;
    logic trk0;
    logic busy;
    logic step_pulse;
    logic done;
    logic hit;
    modport ctrl(output start, count, to_trk0, trk0, input busy, step_pulse, done, hit);
    modport gen(input start, count, to_trk0, trk0, output busy, step_pulse, done, hit);
endinterface
`default_nettype wire

// file: fl_step_gen.sv
// Step pulse generator: issues a counted train of step pulses,
// optionally stopping early when track 0 is reported.
// Assumes trk0 is already synchronised to the core clock.
`timescale 1ns/1ps
`default_nettype none
module fl_step_gen #(
    parameter int unsigned P_STEP_CYC = fl_st0_pkg::STEP_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Control side
    fl_step_if.gen step
);
    localparam int unsigned DIV_W = $clog2(P_STEP_CYC + 1);

    // Track 0 takes about five cycles through the pin synchroniser, so a
    // shorter step period would test it before the last pulse has landed
    if (P_STEP_CYC < 6) begin : g_chk
        $error("P_STEP_CYC must be at least 6");
    end

    logic [DIV_W-1:0] div_r;
    logic [7:0] rem_r;
    logic busy_r;
    logic tick;

    // ==========================================================
    // Step rate divider, restarted while idle so the first pulse
    // always comes one full step period after the start
    assign tick = (div_r == '0);
    assign step.busy = busy_r;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_r <= '0;
        end else if (!busy_r || tick) begin
            div_r <= DIV_W'(P_STEP_CYC - 1);
        end else begin
            div_r <= div_r - 1'b1;
        end
    end

    // ==========================================================
    // Step sequencer; while to_trk0 is set, track 0 is checked before each pulse
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_r <= 1'b0;
            rem_r <= 8'h00;
            step.step_pulse <= 1'b0;
            step.done <= 1'b0;
            step.hit <= 1'b0;
        end else begin
            step.step_pulse <= 1'b0;
            step.done <= 1'b0;
            if (step.start && !busy_r) begin
                busy_r <= 1'b1;
                rem_r <= step.count;
                step.hit <= 1'b0;
            end else if (busy_r && tick) begin
                if (step.to_trk0 && step.trk0) begin
                    busy_r <= 1'b0; // Reached track 0 early
                    step.done <= 1'b1;
                    step.hit <= 1'b1;
                end else if (rem_r == 8'h00) begin
                    busy_r <= 1'b0; // All pulses spent
                    step.done <= 1'b1;
                    step.hit <= step.trk0;
                end else begin
                    step.step_pulse <= 1'b1;
                    rem_r <= rem_r - 8'h01;
                end
            end
        end
    end
endmodule // fl_step_gen
`default_nettype wire

// file: fl_st0_top.sv
// Result status byte zero of the floppy controller, with a small
// command front end, drive pin synchronisers and an AXI4-Lite slave.
// Assumes drive pins are asynchronous and the host polls or uses o_irq.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Seek completion sets seek-done flag
// - Drive fault input sets equipment-fault flag
// - Recalibrate without track 0 after 77 steps faults
// - Read/write on not-ready drive sets not-ready
// - Read/write to side 1 on single-sided drive sets not-ready
// - Head bit holds head at interrupt
// - Unit bits hold drive unit at interrupt
// - Proper completion reports completion code 00
module fl_st0_top #(
    parameter int unsigned P_STEP_CYC = fl_st0_pkg::STEP_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // AXI4-Lite write address and data
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // AXI4-Lite read
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [7:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // Drive pins
    input wire logic i_drv_fault,
    input wire logic i_drv_track0,
    input wire logic i_drv_ready,
    input wire logic i_drv_two_side,
    output logic o_drv_step,
    output logic [1:0] o_drv_unit,
    output logic o_drv_head,
    // Interrupt
    output logic o_irq
);
    localparam int unsigned NPIN = 4;

    fl_step_if step_bus();

    fl_st0_pkg::fl_state_t state_r;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] sync3_r;
    logic [NPIN-1:0] pin_r;
    logic fault_s, trk0_s, ready_s, two_side_s;
    logic [7:0] st0_r;
    logic [1:0] op_r;
    logic [1:0] unit_r;
    logic head_r;
    logic nr_r;
    logic fault_seen_r;
    logic trk0_hit_r;
    logic irq_stat_r;
    logic irq_en_r;
    logic aw_hold_r, w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire, rd_fire, rd_st0, cmd_go, cmd_rw, cmd_nr;
    logic ec_now, se_now;
    logic [7:0] rd_word;
    logic rd_ok, wr_ok;
    logic [1:0] cmd_op;
    logic cmd_head;

    // ==========================================================
    // Pin synchronisers: a level counts once stages two and three agree
    assign pin_raw = {i_drv_two_side, i_drv_ready, i_drv_track0, i_drv_fault};

    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                sync1_r[g] <= 1'b0;
                sync2_r[g] <= 1'b0;
                sync3_r[g] <= 1'b0;
                pin_r[g] <= 1'b0;
            end else begin
                sync1_r[g] <= pin_raw[g];
                sync2_r[g] <= sync1_r[g];
                sync3_r[g] <= sync2_r[g];
                if (sync2_r[g] == sync3_r[g]) begin
                    pin_r[g] <= sync3_r[g];
                end
            end
        end
    end

    assign fault_s = pin_r[0];
    assign trk0_s = pin_r[1];
    assign ready_s = pin_r[2];
    assign two_side_s = pin_r[3];

    // ==========================================================
    // AXI4-Lite handshakes; one write and one read in flight
    assign o_s_axi_awready = !aw_hold_r && !o_s_axi_bvalid;
    assign o_s_axi_wready = !w_hold_r && !o_s_axi_bvalid;
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign wr_fire = aw_hold_r && w_hold_r && !o_s_axi_bvalid;
    assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;
    assign rd_st0 = rd_fire && ({i_s_axi_araddr[7:2], 2'b00} == fl_st0_pkg::OFS_RESULT);

    // Write channel capture, address and data in either order
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= fl_st0_pkg::RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {i_s_axi_awaddr[7:2], 2'b00};
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= i_s_axi_wdata;
                w_strb_r <= i_s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_ok ? fl_st0_pkg::RESP_OKAY : fl_st0_pkg::RESP_SLVERR;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Every word in the map takes writes; read-only words ignore them
    assign wr_ok = (aw_addr_r <= fl_st0_pkg::OFS_CTRL_STAT);

    // Read data mux; write-only words read as zero
    always_comb begin
        rd_word = 8'h00;
        rd_ok = 1'b1;
        case ({i_s_axi_araddr[7:2], 2'b00})
            fl_st0_pkg::OFS_RESULT: rd_word = st0_r;
            fl_st0_pkg::OFS_CMD: rd_word = 8'h00;
            fl_st0_pkg::OFS_IRQ_STAT: rd_word = {7'h00, irq_stat_r};
            fl_st0_pkg::OFS_IRQ_CLR: rd_word = 8'h00;
            fl_st0_pkg::OFS_IRQ_EN: rd_word = {7'h00, irq_en_r};
            fl_st0_pkg::OFS_CTRL_STAT: rd_word = {2'h0, two_side_s, trk0_s, fault_s, ready_s,
                (state_r == fl_st0_pkg::ST_HOLD), step_bus.busy};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= fl_st0_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= {24'h00_0000, rd_word};
            o_s_axi_rresp <= rd_ok ? fl_st0_pkg::RESP_OKAY : fl_st0_pkg::RESP_SLVERR;
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Command decode; commands are dropped unless idle
    assign cmd_op = w_data_r[fl_st0_pkg::CMD_OP_LSB +: 2];
    assign cmd_head = w_data_r[fl_st0_pkg::CMD_HEAD_BIT];
    assign cmd_go = wr_fire && (aw_addr_r == fl_st0_pkg::OFS_CMD) && w_strb_r[0]
        && (state_r == fl_st0_pkg::ST_IDLE);
    assign cmd_rw = (cmd_op == fl_st0_pkg::OP_READ) || (cmd_op == fl_st0_pkg::OP_WRITE);
    assign cmd_nr = cmd_rw && (!ready_s || (cmd_head && !two_side_s));

    assign step_bus.start = cmd_go && !cmd_rw;
    assign step_bus.to_trk0 = (op_r == fl_st0_pkg::OP_RECAL);
    assign step_bus.trk0 = trk0_s;
    // Recalibrate always gets the full 77-pulse budget
    assign step_bus.count = (cmd_op == fl_st0_pkg::OP_RECAL) ? 8'(fl_st0_pkg::RECAL_STEPS) :
        (w_strb_r[1] ? w_data_r[fl_st0_pkg::CMD_CNT_LSB +: 8] : 8'h00);

    // Command context latched at acceptance
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            op_r <= fl_st0_pkg::OP_SEEK;
            unit_r <= 2'h0;
            head_r <= 1'b0;
            nr_r <= 1'b0;
        end else if (cmd_go) begin
            op_r <= cmd_op;
            unit_r <= w_data_r[fl_st0_pkg::CMD_UNIT_LSB +: 2];
            head_r <= cmd_head;
            nr_r <= cmd_nr;
        end
    end

    // Fault and track 0 history over the command's life
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fault_seen_r <= 1'b0;
            trk0_hit_r <= 1'b0;
        end else if (cmd_go) begin
            fault_seen_r <= fault_s;
            trk0_hit_r <= 1'b0;
        end else begin
            if (fault_s) begin
                fault_seen_r <= 1'b1;
            end
            if (step_bus.done) begin
                trk0_hit_r <= step_bus.hit;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= fl_st0_pkg::ST_IDLE;
        end else begin
            case (state_r)
                fl_st0_pkg::ST_IDLE: begin
                    if (cmd_go) begin
                        state_r <= cmd_rw ? fl_st0_pkg::ST_CAP : fl_st0_pkg::ST_STEP;
                    end
                end
                fl_st0_pkg::ST_STEP: begin
                    if (step_bus.done) begin
                        state_r <= fl_st0_pkg::ST_CAP;
                    end
                end
                fl_st0_pkg::ST_CAP: state_r <= fl_st0_pkg::ST_HOLD;
                fl_st0_pkg::ST_HOLD: begin
                    if (rd_st0) begin
                        state_r <= fl_st0_pkg::ST_IDLE; // Host took the byte
                    end
                end
                default: state_r <= fl_st0_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Result capture at termination only, so a late pin change
    // cannot alter a byte the host has not yet read
    assign ec_now = fault_seen_r || fault_s
        || ((op_r == fl_st0_pkg::OP_RECAL) && !trk0_hit_r);
    assign se_now = (op_r == fl_st0_pkg::OP_SEEK) || (op_r == fl_st0_pkg::OP_RECAL);

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st0_r <= fl_st0_pkg::RESULT_RST;
        end else if (state_r == fl_st0_pkg::ST_CAP) begin
            st0_r[fl_st0_pkg::B_CODE_LSB +: 2] <= (ec_now || nr_r) ?
                fl_st0_pkg::CODE_ABNORMAL : fl_st0_pkg::CODE_NORMAL;
            st0_r[fl_st0_pkg::B_SEEK_DONE] <= se_now;
            st0_r[fl_st0_pkg::B_EQUIP_FAULT] <= ec_now;
            st0_r[fl_st0_pkg::B_NOT_READY] <= nr_r;
            st0_r[fl_st0_pkg::B_HEAD] <= head_r;
            st0_r[1:0] <= unit_r;
        end
    end

    // ==========================================================
    // Interrupt: sticky done bit, set beats a same-cycle clear
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_stat_r <= 1'b0;
            irq_en_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            if (state_r == fl_st0_pkg::ST_CAP) begin
                irq_stat_r <= 1'b1;
            end else if (wr_fire && (aw_addr_r == fl_st0_pkg::OFS_IRQ_CLR) && w_strb_r[0]
                && w_data_r[fl_st0_pkg::IRQ_DONE]) begin
                irq_stat_r <= 1'b0;
            end
            if (wr_fire && (aw_addr_r == fl_st0_pkg::OFS_IRQ_EN) && w_strb_r[0]) begin
                irq_en_r <= w_data_r[fl_st0_pkg::IRQ_DONE];
            end
            o_irq <= irq_stat_r && irq_en_r;
        end
    end

    // ==========================================================
    // Drive outputs follow the latched command
    assign o_drv_step = step_bus.step_pulse;
    assign o_drv_unit = unit_r;
    assign o_drv_head = head_r;

    fl_step_gen #(
        .P_STEP_CYC(P_STEP_CYC)
    ) u_step (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .step(step_bus)
    );

    // ==========================================================
    // Checks
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_seek_done_flag: assert property ((state_r == fl_st0_pkg::ST_CAP) && (op_r == fl_st0_pkg::OP_SEEK)
        |=> st0_r[fl_st0_pkg::B_SEEK_DONE]) else $error("seek done flag not set");
    a_fault_sets_ec: assert property ((state_r == fl_st0_pkg::ST_STEP) && step_bus.done && fault_s
        |-> ##2 st0_r[fl_st0_pkg::B_EQUIP_FAULT]) else $error("fault not reported");
    a_recal_fault_ec: assert property (step_bus.done && step_bus.to_trk0 && !step_bus.hit
        |-> ##2 st0_r[fl_st0_pkg::B_EQUIP_FAULT]) else $error("recal miss not reported");
    a_not_ready_nr: assert property (cmd_go && cmd_rw && !ready_s
        |-> ##2 st0_r[fl_st0_pkg::B_NOT_READY]) else $error("not ready missed");
    a_single_side_nr: assert property (cmd_go && cmd_rw && cmd_head && !two_side_s
        |-> ##2 st0_r[fl_st0_pkg::B_NOT_READY]) else $error("side 1 on single side missed");
    a_head_at_irq: assert property ((state_r == fl_st0_pkg::ST_CAP)
        |=> st0_r[fl_st0_pkg::B_HEAD] == $past(head_r)) else $error("head bit wrong");
    a_unit_at_irq: assert property ($rose(irq_stat_r)
        |-> st0_r[1:0] == o_drv_unit) else $error("unit bits wrong");
    a_normal_code: assert property ((state_r == fl_st0_pkg::ST_CAP) && !ec_now && !nr_r
        |=> st0_r[7:6] == fl_st0_pkg::CODE_NORMAL) else $error("normal code wrong");
    a_hold_stable: assert property ((state_r == fl_st0_pkg::ST_HOLD) && !rd_st0
        |=> $stable(st0_r) && (state_r == fl_st0_pkg::ST_HOLD)) else $error("result changed before read");
endmodule // fl_st0_top
`default_nettype wire

// file: fl_drive_model.sv
// Behavioural drive head model: track position and track 0 sense.
// Assumes each step pulse moves the head one track towards track 0.
`timescale 1ns/1ps
`default_nettype none
module fl_drive_model (
    // Clock and head placement
    input wire logic i_core_clk,
    input wire logic i_load,
    input wire logic [7:0] i_pos,
    // Drive pins
    input wire logic i_step,
    output logic o_track0
);
    // ==========
    // Head position
    logic [7:0] pos_r;
    // A position past the step limit models a head that never finds track 0
    always_ff @(posedge i_core_clk) begin
        if (i_load) begin
            pos_r <= i_pos;
        end else if (i_step && pos_r != 8'h00) begin
            pos_r <= pos_r - 8'h01;
        end
    end
    // Sense is a plain level, active only at the outermost track
    assign o_track0 = (pos_r == 8'h00);
endmodule // fl_drive_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the status byte zero block.
// Assumes the block, its package and the drive model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========
    // Stimulus and observed signals
    logic clk, rst, awv, wv, bry, arv, rry, fault, ready, two, load;
    logic [7:0] awa, ara, pos;
    logic [31:0] wd, rd, rd_v;
    logic [3:0] ws;
    logic awr, wrdy, bv, arr, rv, step, head, irq, trk0;
    logic [1:0] br, rr, unit, resp_v;
    int fail_count, samples_checked, steps;

    // Half period of the 125 MHz clock
    always #4 clk = ~clk;
    // Step pulses are one cycle wide, so one count per edge
    always @(posedge clk) if (step === 1'b1) steps++;

    fl_st0_top #(.P_STEP_CYC(8)) fl_st0_top_inst (
        .i_core_clk(clk), .i_sys_rst(rst),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
        .i_drv_fault(fault), .i_drv_track0(trk0), .i_drv_ready(ready), .i_drv_two_side(two),
        .o_drv_step(step), .o_drv_unit(unit), .o_drv_head(head), .o_irq(irq));

    fl_drive_model fl_drive_model_inst (
        .i_core_clk(clk), .i_load(load), .i_pos(pos), .i_step(step), .o_track0(trk0));

    // ==========
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic timeout(input string msg);
        fail_count++;
        $display("CHECK FAILED at %0t: %s wait ran out", $time, msg);
        stop_test();
    endtask

    // ==========
    // Bus master: payload held until each channel is taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic aw_ok, w_ok, got;
        aw_ok = 0;
        w_ok = 0;
        got = 0;
        @(posedge clk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'hF; bry <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(posedge clk);
            if (!aw_ok && awr) begin aw_ok = 1; awv <= 1'b0; end
            if (!w_ok && wrdy) begin w_ok = 1; wv <= 1'b0; end
            if (bv) begin got = 1; resp = br; bry <= 1'b0; end
        end
        if (!got) timeout("write");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_ok, got;
        ar_ok = 0;
        got = 0;
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(posedge clk);
            if (!ar_ok && arr) begin ar_ok = 1; arv <= 1'b0; end
            if (rv) begin got = 1; d = rd; resp = rr; rry <= 1'b0; end
        end
        if (!got) timeout("read");
    endtask

    // ==========
    // Command helpers: issue, wait for the interrupt, then read and clear
    task automatic run_cmd(input logic [1:0] op, input logic [1:0] u, input logic h, input logic [7:0] c);
        int n;
        steps = 0;
        axi_wr(8'h04, {16'h0, c, 3'h0, h, u, op}, resp_v);
        chk(resp_v, fl_st0_pkg::RESP_OKAY, "command write answer");
        for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
        if (irq !== 1'b1) timeout("command");
        chk({head, unit}, {h, u}, "drive head and unit");
    endtask
    task automatic end_cmd(input logic [7:0] exp, input string msg);
        axi_rd(fl_st0_pkg::OFS_RESULT, rd_v, resp_v);
        chk(rd_v, {24'h0, exp}, msg);
        axi_wr(fl_st0_pkg::OFS_IRQ_CLR, 32'h1, resp_v);
    endtask

    // ==========
    // Scenarios
    task automatic t_regs();
        axi_rd(fl_st0_pkg::OFS_RESULT, rd_v, resp_v);
        chk(rd_v, 32'h0, "result after reset");
        axi_rd(8'h40, rd_v, resp_v);
        chk(resp_v, fl_st0_pkg::RESP_SLVERR, "unmapped read");
        axi_wr(8'h40, 32'h1, resp_v);
        chk(resp_v, fl_st0_pkg::RESP_SLVERR, "unmapped write");
        axi_wr(fl_st0_pkg::OFS_IRQ_EN, 32'h1, resp_v);
        axi_rd(fl_st0_pkg::OFS_IRQ_EN, rd_v, resp_v);
        chk(rd_v, 32'h1, "irq enable");
        $display("test registers done");
    endtask
    task automatic t_seek();
        run_cmd(fl_st0_pkg::OP_SEEK, 2'h2, 1'b1, 8'h03);
        chk(steps, 3, "seek steps");
        fault <= 1'b1;
        axi_wr(fl_st0_pkg::OFS_CMD, 32'h0000_0500, resp_v);
        chk(resp_v, fl_st0_pkg::RESP_OKAY, "command while held answer");
        repeat (10) @(posedge clk);
        end_cmd(8'h26, "seek result held");
        chk(steps, 3, "command while held dropped");
        repeat (3) @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        axi_rd(fl_st0_pkg::OFS_IRQ_STAT, rd_v, resp_v);
        chk(rd_v, 32'h0, "irq status cleared");
        fault <= 1'b0;
        repeat (8) @(posedge clk);
        $display("test seek done");
    endtask
    task automatic t_recal();
        run_cmd(fl_st0_pkg::OP_RECAL, 2'h1, 1'b0, 8'h00);
        chk(steps, 77, "recal step limit");
        end_cmd(8'h71, "recal without track 0");
        pos <= 8'h05;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        run_cmd(fl_st0_pkg::OP_RECAL, 2'h0, 1'b0, 8'h00);
        end_cmd(8'h20, "recal reaching track 0");
        $display("test recalibrate done");
    endtask
    task automatic t_ready();
        ready <= 1'b0;
        repeat (8) @(posedge clk);
        run_cmd(fl_st0_pkg::OP_READ, 2'h3, 1'b0, 8'h00);
        end_cmd(8'h4B, "read on not ready drive");
        ready <= 1'b1;
        two <= 1'b0;
        repeat (8) @(posedge clk);
        run_cmd(fl_st0_pkg::OP_WRITE, 2'h0, 1'b1, 8'h00);
        end_cmd(8'h4C, "side 1 of single sided drive");
        two <= 1'b1;
        repeat (8) @(posedge clk);
        run_cmd(fl_st0_pkg::OP_READ, 2'h1, 1'b1, 8'h00);
        end_cmd(8'h05, "read normal");
        $display("test not ready done");
    endtask
    task automatic t_fault();
        fault <= 1'b1;
        repeat (8) @(posedge clk);
        run_cmd(fl_st0_pkg::OP_SEEK, 2'h0, 1'b0, 8'h02);
        end_cmd(8'h70, "seek with drive fault");
        fault <= 1'b0;
        $display("test fault done");
    endtask

    // ==========
    // Main sequence
    initial begin
        clk = 0; rst = 1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
        awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'h0;
        fault = 0; ready = 1; two = 1; pos = 8'hC8; load = 1;
        fail_count = 0; samples_checked = 0; steps = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        load <= 1'b0;
        repeat (8) @(posedge clk);
        t_regs();
        t_seek();
        t_recal();
        t_ready();
        t_fault();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
